// ### hw/rfc_params.svh
// Function
// - no pause frame or jam while the transmitter is disabled; JAM_O can stay high for one cycle after TX_EN_I falls.
// - high level field bits 23:16 in 64-byte units triggers flow control.
// - full duplex high crossing sends exactly one pause frame with programmed time.
// - half duplex jams each matching frame for the programmed duration after trigger.
// - low level field bits 15:8; falling below sends zero-time pause frame.
// - zero-time pause only after a high pause was sent, while enabled.
// - duration field bits 7:4 sets jam length, ignored in full duplex.
// - bit 3 jams multicast frames after trigger, half duplex only.
// - bit 2 jams broadcast frames after trigger, half duplex only.
// - bit 1 jams own-address frames after trigger, half duplex only.
// - bit 0 any frame, overrides 3:1; jam on preamble, or queue pause.
// - duration codes 5,10,15,25..600 us at 100M; plus 2.2 us at 10M.
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH
`define RFC_CFG_ADDR 8'hAC
`define RFC_HI_MSB 23
`define RFC_HI_LSB 16
`define RFC_LO_MSB 15
`define RFC_LO_LSB 8
`define RFC_DUR_MSB 7
`define RFC_DUR_LSB 4
`define RFC_BIT_MULT 3
`define RFC_BIT_BRD 2
`define RFC_BIT_ADDR 1
`define RFC_BIT_ANY 0
`define RFC_CFG_MASK 32'h00FFFFFF
`define RFC_UNIT_SHIFT 6
`define RFC_CLK_MHZ 25
`define RFC_EXTRA_NS 2200
`endif

// ### hw/rfc_pkg.sv
package rfc_pkg;
    typedef enum logic [1:0] {RFC_IDLE, RFC_PAUSED} rfc_state_type;
    typedef struct packed {
        logic sof;
        logic multicast;
        logic broadcast;
        logic own_addr;
    } rfc_frame_type;
    typedef struct packed {
        logic req;
        logic zero_time;
    } rfc_pause_type;
endpackage : rfc_pkg

// ### hw/rfc_flow_ctrl.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "rfc_params.svh"
module rfc_flow_ctrl
    import rfc_pkg::*;
#(
    parameter int FIFO_AW = 14
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic [FIFO_AW:0] RX_LEVEL_I,
    input wire logic TX_EN_I,
    input wire logic FULL_DUPLEX_I,
    input wire logic SPEED_100_I,
    input wire rfc_frame_type FRAME_I,
    output rfc_pause_type PAUSE_O,
    input wire logic PAUSE_ACK_I,
    output logic JAM_O
);
    logic [31:0] cfg;
    rfc_state_type state;
    logic pending;
    logic pend_zero;
    logic [23:0] jam_cnt;
    logic [23:0] next_jam_len;
    logic [23:0] extra;
    logic [FIFO_AW+2:0] hi_bytes;
    logic [FIFO_AW+2:0] lo_bytes;
    logic [FIFO_AW+2:0] lvl;
    logic hi_hit;
    logic lo_hit;
    logic enabled;
    logic match;
    logic [7:0] hi_f;
    logic [7:0] lo_f;
    logic [3:0] dur;
    // field extraction
    assign hi_f = cfg[`RFC_HI_MSB:`RFC_HI_LSB];
    assign lo_f = cfg[`RFC_LO_MSB:`RFC_LO_LSB];
    assign dur = cfg[`RFC_DUR_MSB:`RFC_DUR_LSB];
    assign enabled = |cfg[`RFC_BIT_MULT:`RFC_BIT_ANY];
    // thresholds scaled to bytes
    assign hi_bytes = {{(FIFO_AW-5){1'b0}}, hi_f} << `RFC_UNIT_SHIFT;
    assign lo_bytes = {{(FIFO_AW-5){1'b0}}, lo_f} << `RFC_UNIT_SHIFT;
    assign lvl = {2'b00, RX_LEVEL_I};
    assign hi_hit = lvl >= hi_bytes;
    assign lo_hit = lvl < lo_bytes;
    // frame selection; any-frame overrides the rest
    always_comb begin
        if (cfg[`RFC_BIT_ANY]) begin
            match = FRAME_I.sof;
        end else begin
            match = FRAME_I.sof & ((cfg[`RFC_BIT_MULT] & FRAME_I.multicast)
                | (cfg[`RFC_BIT_BRD] & FRAME_I.broadcast)
                | (cfg[`RFC_BIT_ADDR] & FRAME_I.own_addr));
        end
    end
    // jam length in cycles from the duration code
    always_comb begin
        extra = SPEED_100_I ? 24'h000000 : 24'(`RFC_EXTRA_NS * `RFC_CLK_MHZ / 1000);
        case (dur)
            4'h0: next_jam_len = 24'(5 * `RFC_CLK_MHZ) + extra;
            4'h1: next_jam_len = 24'(10 * `RFC_CLK_MHZ) + extra;
            4'h2: next_jam_len = 24'(15 * `RFC_CLK_MHZ) + extra;
            4'h3: next_jam_len = 24'(25 * `RFC_CLK_MHZ) + extra;
            default: next_jam_len = 24'(32'(dur - 4'h3) * 50 * `RFC_CLK_MHZ) + extra;
        endcase
    end
    // configuration register
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            cfg <= 32'h00000000;
        end else if (WR_I && ADDR_I == `RFC_CFG_ADDR) begin
            cfg <= WDATA_I & `RFC_CFG_MASK;
        end
    end
    // read data, one cycle after the strobe
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 32'h00000000;
        end else if (RD_I && ADDR_I == `RFC_CFG_ADDR) begin
            RDATA_O <= cfg;
        end else begin
            RDATA_O <= 32'h00000000;
        end
    end
    // full duplex pause sequencing
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            state <= RFC_IDLE;
            pending <= 1'b0;
            pend_zero <= 1'b0;
        end else if (pending) begin
            if (PAUSE_ACK_I) begin
                pending <= 1'b0;
            end
        end else begin
            case (state)
                RFC_IDLE: begin
                    // bits 3:1 cannot arm a pause in full duplex, only any-frame does; they still count toward enabled in RFC_PAUSED
                    if (cfg[`RFC_BIT_ANY] && FULL_DUPLEX_I && TX_EN_I && hi_hit) begin
                        pending <= 1'b1;
                        pend_zero <= 1'b0;
                        state <= RFC_PAUSED;
                    end
                end
                RFC_PAUSED: begin
                    if (!enabled) begin
                        state <= RFC_IDLE;
                    end else if (lo_hit && TX_EN_I) begin
                        pending <= 1'b1;
                        pend_zero <= 1'b1;
                        state <= RFC_IDLE;
                    end
                end
                default: state <= RFC_IDLE;
            endcase
        end
    end
    assign PAUSE_O.req = pending & TX_EN_I;
    assign PAUSE_O.zero_time = pend_zero;
    // half duplex jam timer
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            jam_cnt <= 24'h000000;
        end else if (!TX_EN_I || FULL_DUPLEX_I) begin
            jam_cnt <= 24'h000000;
        end else if (jam_cnt == 24'h000000 && hi_hit && match) begin
            jam_cnt <= next_jam_len;
        end else if (jam_cnt != 24'h000000) begin
            jam_cnt <= jam_cnt - 24'h000001;
        end
    end
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            JAM_O <= 1'b0;
        end else begin
            JAM_O <= (jam_cnt > 24'h000001) && TX_EN_I && !FULL_DUPLEX_I;
        end
    end
endmodule : rfc_flow_ctrl

// ### tb/rfc_flow_ctrl_monitor.sv
`timescale 1ns/1ps
module rfc_flow_ctrl_monitor
    import rfc_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic TX_EN_I,
    input wire logic FULL_DUPLEX_I,
    input wire rfc_frame_type FRAME_I,
    input wire rfc_pause_type PAUSE_O,
    input wire logic PAUSE_ACK_I,
    input wire logic JAM_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    AST_TX_REQ: assert property (!TX_EN_I |-> !PAUSE_O.req) else $error("req, tx off");
    AST_TX_JAM: assert property (!TX_EN_I |=> !JAM_O) else $error("jam, tx off");
    AST_FD_JAM: assert property (FULL_DUPLEX_I |=> !JAM_O) else $error("jam, full duplex");
    AST_JAM_SOF: assert property ($rose(JAM_O) |-> $past(FRAME_I.sof, 2)) else $error("jam, no sof");
    AST_REQ_HOLD: assert property (PAUSE_O.req && !PAUSE_ACK_I && TX_EN_I |=>
        (PAUSE_O.req || !TX_EN_I) && $stable(PAUSE_O.zero_time)) else $error("req dropped");
    AST_ACK_DROP: assert property (PAUSE_ACK_I |=> !PAUSE_O.req) else $error("second pause");
    AST_RD_RSV: assert property ($past(RD_I) |-> RDATA_O[31:24] == 8'h00) else $error("reserved bits");
    AST_JAM_HOLD: assert property ($rose(JAM_O) && TX_EN_I && !FULL_DUPLEX_I |=> JAM_O) else $error("short jam");
    cover property (PAUSE_O.req && PAUSE_O.zero_time);
    cover property (PAUSE_O.req && !PAUSE_O.zero_time);
    cover property ($rose(JAM_O));
endmodule : rfc_flow_ctrl_monitor
bind rfc_flow_ctrl rfc_flow_ctrl_monitor u_mon (.*);

// ### tb/rfc_mac_model.sv
`timescale 1ns/1ps
module rfc_mac_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [3:0] lag_i,
    output logic ack_o
);
    int wait_cnt = 0;
    initial ack_o = 1'b0;
    // accept a pending pause after lag cycles, one pulse each
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        wait_cnt <= (req_i && !ack_o) ? wait_cnt + 1 : 0;
        if (req_i && !ack_o && wait_cnt >= int'(lag_i)) ack_o <= 1'b1;
    end
endmodule : rfc_mac_model

// ### tb/test_rx_auto_flow_control.sv
`timescale 1ns/1ps
module test_rx_auto_flow_control import rfc_pkg::*;;
    logic clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, tx_en = 1, fd = 1, spd = 1, ack, jam;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'hF64D;
    logic [14:0] level = 15'h0;
    logic [3:0] lag = 4'h0;
    rfc_frame_type frame = '0;
    rfc_pause_type pause;
    int err_count = 0, samples_checked = 0, n;
    rfc_flow_ctrl dut (.MCLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .RX_LEVEL_I(level), .TX_EN_I(tx_en), .FULL_DUPLEX_I(fd),
        .SPEED_100_I(spd), .FRAME_I(frame), .PAUSE_O(pause), .PAUSE_ACK_I(ack), .JAM_O(jam));
    rfc_mac_model mac (.clk_i(clk), .req_i(pause.req), .lag_i(lag), .ack_o(ack));
    always #20 clk = ~clk;
    task chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task bus(input logic w, input logic [31:0] d, input logic [7:0] a);
        @(posedge clk);
        {wr_s, rd_s, addr, wdata} <= {w, !w, a, d};
        @(posedge clk);
        {wr_s, rd_s} <= 2'b00;
        @(negedge clk);
        rv = rdata;
    endtask : bus
    task step(input int v, input logic want, zt);
        @(posedge clk) level <= v[14:0];
        n = 0;
        repeat (2) @(negedge clk);
        while (want && pause.req !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (!want) repeat (8) @(negedge clk);
        chk("req", pause.req, want);
        if (want) chk("zero_time", pause.zero_time, zt);
        repeat (14) @(negedge clk);
    endtask : step
    task jam_run(input logic [2:0] cls, input logic [3:0] fc, code);
        int exp;
        exp = (code < 3 ? 5 * (code + 1) : 25 + 50 * (code - 3)) * 25 + (seed[4] ? 0 : 55);
        bus(1, {8'h00, 8'h02, 8'h01, code, fc}, 8'hAC);
        @(posedge clk) {spd, frame} <= {seed[4], 1'b1, cls};
        @(posedge clk) frame <= '0;
        n = 0;
        while (jam !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (jam === 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk("jam_len", n > exp - 3 && n < exp + 3, fc[0] || |(fc[3:1] & cls));
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endtask : jam_run
    task complete_run;
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        #1ms;
        err_count++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        bus(1, (seed & 32'hFFFFFFF0) | 32'hFF000000, 8'hAC);
        bus(0, 0, 8'hAC);
        chk("cfg", rv, seed & 32'h00FFFFF0);
        bus(0, 0, 8'hA8);
        chk("unmapped", rv, 0);
        bus(1, 32'h00020101, 8'hAC);
        step(127, 0, 0);
        step(128, 1, 0);
        @(posedge clk) lag <= 4'h5;
        step(200, 0, 0);
        step(64, 0, 0);
        @(posedge clk) tx_en <= 0;
        step(63, 0, 0);
        @(posedge clk) tx_en <= 1;
        step(63, 1, 1);
        step(128, 1, 0);
        @(posedge clk) fd <= 0;
        for (int i = 0; i < 3; i++) jam_run(3'b100 >> i, {3'b100 >> i, 1'b0}, {2'b00, seed[1:0]});
        jam_run(3'b010, 4'b1000, 0);
        jam_run(3'b000, 4'b0001, 1);
        complete_run;
    end
endmodule : test_rx_auto_flow_control
